// *** efield_select_and_supervisor.v ***
// Overview of operation
// - select bits decode binary, sel_d msb
// - codes 0,12,13,14 internal; 15 reserved
// - sine goes to one selected pin
// - unselected electrodes and references grounded
// - receive follows driven pin simultaneously
// - receive may also pick internal nodes
// - square clock out at oscillator rate
// - supervisor timing counts oscillator periods
// - reset held until supply good timeout
// - undervoltage reasserts reset, restarts timeout
// - overvoltage forces reset
// - missing kick edge forces reset
// - watchdog reset held for hold time
// - lamp switch closed while requested
// - serial data passes through both ways
//
// Purpose: control logic of the electric-field companion: selectors and supervisor
// Assumes: all inputs synchronous to i_clk; supply detectors are digital levels
// Notes: analog switches are represented by enable levels
`timescale 1ns/1ps
`include "efield_defines.vh"

module efield_select_and_supervisor (
   input wire i_clk,
   input wire i_rst,
   input wire i_sel_a,
   input wire i_sel_b,
   input wire i_sel_c,
   input wire i_sel_d,
   input wire i_vcc_low,
   input wire i_vcc_high,
   input wire i_wd_kick,
   input wire i_lamp_on_req,
   input wire i_serial_bus_rx,
   input wire i_serial_tx_in,
   output reg [`PIN_W-1:0] o_tx_drive,
   output reg [`PIN_W-1:0] o_pin_ground,
   output reg [`RX_W-1:0] o_rx_connect,
   output wire o_clk_out,
   output reg o_rst_n,
   output reg o_lamp_switch,
   output reg o_serial_rx_out,
   output reg o_serial_bus_tx
);

   // ---------------------------------------------------------------
   // select decode
   // ---------------------------------------------------------------
   wire [3:0] sel_w = {i_sel_d, i_sel_c, i_sel_b, i_sel_a};

   // one-hot pin index for codes 1..11, zero otherwise
   function [`PIN_W-1:0] pin_onehot;
      input [3:0] code;
      begin
         pin_onehot = {`PIN_W{1'b0}};
         if (code >= `SEL_E_FIRST && code <= `SEL_REF_B)
            pin_onehot[code - `SEL_E_FIRST] = 1'b1;
      end
   endfunction

   // detector source: the driven pin, an internal node, or nothing at all
   function [`RX_W-1:0] rx_onehot;
      input [3:0] code;
      reg [`RX_W-1:0] src;
      begin
         src = {`RX_W{1'b0}};
         case (code)
            `SEL_SOURCE: src[`RX_SOURCE] = 1'b1;
            `SEL_OSC: src[`RX_OSC] = 1'b1;
            `SEL_OSC_RES: src[`RX_OSC_RES] = 1'b1;
            // internal ground: detector sees no source, nothing driven
            `SEL_GND: src = {`RX_W{1'b0}};
            `SEL_RSVD: src = {`RX_W{1'b0}};
            default: src[`PIN_W-1:0] = pin_onehot(code);
         endcase
         rx_onehot = src;
      end
   endfunction

   reg [`PIN_W-1:0] drive_d;
   reg [`RX_W-1:0] rx_d;

   always @* begin
      drive_d = pin_onehot(sel_w);
      rx_d = rx_onehot(sel_w);
   end

   // ---------------------------------------------------------------
   // selector switches
   // ---------------------------------------------------------------
   // drive, ground and receive all move on one edge, so a pin is never
   // driven while grounded and the detector never looks at a stale pin
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_tx_drive <= {`PIN_W{1'b0}};
      end else begin
         o_tx_drive <= drive_d;
      end
   end

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pin_ground <= {`PIN_W{1'b1}};
      end else begin
         o_pin_ground <= ~drive_d;
      end
   end

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rx_connect <= {`RX_W{1'b0}};
      end else begin
         o_rx_connect <= rx_d;
      end
   end

   // ---------------------------------------------------------------
   // oscillator
   // ---------------------------------------------------------------
   // divider stands in for the analog oscillator; its tick paces the supervisor
   wire osc_tick;

   osc_tick_gen u_osc (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .o_osc_clk(o_clk_out),
      .o_osc_tick(osc_tick)
   );

   // ---------------------------------------------------------------
   // supervisor helpers
   // ---------------------------------------------------------------
   // one more oscillator period; all windows stay far below the counter range
   function [`TICK_W-1:0] cnt_inc;
      input [`TICK_W-1:0] cnt;
      begin
         cnt_inc = cnt + 1'b1;
      end
   endfunction

   // true in the last oscillator period of a window
   // ticks is the window length, so the count runs 0 .. ticks-1
   function last_period;
      input [`TICK_W-1:0] cnt;
      input [31:0] ticks;
      begin
         last_period = (cnt == ticks - 32'h00000001);
      end
   endfunction

   // ---------------------------------------------------------------
   // kick edge detect
   // ---------------------------------------------------------------
   reg kick_q;

   // cleared to the idle level of the pin so reset gives no false edge
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         kick_q <= 1'b0;
      end else begin
         kick_q <= i_wd_kick;
      end
   end

   wire kick_rise = i_wd_kick & ~kick_q;

   // ---------------------------------------------------------------
   // reset supervisor
   // ---------------------------------------------------------------
   // por: wait for a good supply; run: watch the kicks; hold: forced
   // reset after a missed kick; a supply fault in any state returns to por
   // and restarts the whole timeout
   localparam ST_POR = 2'b00;
   localparam ST_RUN = 2'b01;
   localparam ST_HOLD = 2'b10;

   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [`TICK_W-1:0] cnt_q;
   reg [`TICK_W-1:0] cnt_d;
   reg kick_seen_q;
   reg kick_seen_d;

   wire supply_bad = i_vcc_low | i_vcc_high;

   always @* begin
      state_d = state_q;
      cnt_d = cnt_q;
      // latch kicks between oscillator ticks so none is missed
      kick_seen_d = kick_seen_q | kick_rise;
      case (state_q)
         ST_POR: begin
            if (supply_bad) begin
               cnt_d = {`TICK_W{1'b0}};
            end else if (osc_tick) begin
               if (last_period(cnt_q, `POR_TICKS)) begin
                  state_d = ST_RUN;
                  cnt_d = {`TICK_W{1'b0}};
                  kick_seen_d = 1'b0;
               end else begin
                  cnt_d = cnt_inc(cnt_q);
               end
            end
         end
         ST_RUN: begin
            if (supply_bad) begin
               state_d = ST_POR;
               cnt_d = {`TICK_W{1'b0}};
            end else if (kick_seen_d) begin
               cnt_d = {`TICK_W{1'b0}};
               kick_seen_d = 1'b0;
            end else if (osc_tick) begin
               // host must kick well inside this window
               if (last_period(cnt_q, `WD_TICKS)) begin
                  state_d = ST_HOLD;
                  cnt_d = {`TICK_W{1'b0}};
               end else begin
                  cnt_d = cnt_inc(cnt_q);
               end
            end
         end
         ST_HOLD: begin
            kick_seen_d = 1'b0;
            if (supply_bad) begin
               state_d = ST_POR;
               cnt_d = {`TICK_W{1'b0}};
            end else if (osc_tick) begin
               if (last_period(cnt_q, `WDHOLD_TICKS)) begin
                  state_d = ST_RUN;
                  cnt_d = {`TICK_W{1'b0}};
               end else begin
                  cnt_d = cnt_inc(cnt_q);
               end
            end
         end
         default: begin
            state_d = ST_POR;
            cnt_d = {`TICK_W{1'b0}};
         end
      endcase
   end

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q <= ST_POR;
         cnt_q <= {`TICK_W{1'b0}};
         kick_seen_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         kick_seen_q <= kick_seen_d;
      end
   end

   // ---------------------------------------------------------------
   // reset output
   // ---------------------------------------------------------------
   // taken from the next state so the pin falls on the edge that sees the fault
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rst_n <= 1'b0;
      end else begin
         o_rst_n <= (state_d == ST_RUN);
      end
   end

   // ---------------------------------------------------------------
   // lamp switch
   // ---------------------------------------------------------------
   // closes one clock after the request; current limiting is analog
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_lamp_switch <= 1'b0;
      end else begin
         o_lamp_switch <= i_lamp_on_req;
      end
   end

   // ---------------------------------------------------------------
   // serial pass-through
   // ---------------------------------------------------------------
   // idle high, so the line reads as released while reset is applied
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_serial_rx_out <= 1'b1;
      end else begin
         o_serial_rx_out <= i_serial_bus_rx;
      end
   end

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_serial_bus_tx <= 1'b1;
      end else begin
         o_serial_bus_tx <= i_serial_tx_in;
      end
   end

endmodule

// *** efield_defines.vh ***
// Purpose: constants for the electric-field select and reset supervisor
// Assumes: 10 MHz system clock; internal oscillator nominal 120 kHz
// Notes: times kept in their own unit, cycle counts derived from them
`ifndef EFIELD_DEFINES_VH
`define EFIELD_DEFINES_VH

// ---------------------------------------------------------------
// clock and oscillator
// ---------------------------------------------------------------
`define CLK_HZ 10000000
`define OSC_HZ 120000
// half period of the oscillator in system clocks (10e6/120e3/2 = 41.67, truncated to 41)
`define OSC_HALF_CYC (`CLK_HZ / (2 * `OSC_HZ))
`define OSC_DIV_W 6

// ---------------------------------------------------------------
// supervisor times, in ms, and derived oscillator counts
// ---------------------------------------------------------------
`define POR_MIN_MS 9
`define POR_MAX_MS 50
`define WD_MIN_MS 50
`define WD_TYP_MS 68
`define WD_MAX_MS 250
`define WDHOLD_MIN_MS 9
`define WDHOLD_MAX_MS 50
// counts in oscillator periods; por and hold use the midpoint of the window
`define POR_TICKS (`OSC_HZ * (`POR_MIN_MS + `POR_MAX_MS) / 2 / 1000)
`define WD_TICKS (`OSC_HZ * `WD_TYP_MS / 1000)
`define WDHOLD_TICKS (`OSC_HZ * (`WDHOLD_MIN_MS + `WDHOLD_MAX_MS) / 2 / 1000)
`define TICK_W 16

// ---------------------------------------------------------------
// select codes
// ---------------------------------------------------------------
`define SEL_SOURCE 4'h0
`define SEL_E_FIRST 4'h1
`define SEL_E_LAST 4'h9
`define SEL_REF_A 4'ha
`define SEL_REF_B 4'hb
`define SEL_OSC 4'hc
`define SEL_OSC_RES 4'hd
`define SEL_GND 4'he
`define SEL_RSVD 4'hf

// receive selector one-hot sources
`define RX_W 14
`define RX_SOURCE 11
`define RX_OSC 12
`define RX_OSC_RES 13
`define RX_GND_BIT 13
`define PIN_W 11

`endif

// *** osc_tick_gen.v ***
// Purpose: oscillator model giving a square wave and a per-period tick
// Assumes: one system clock; the analog oscillator is replaced by a divider
// Notes: tick is one system cycle wide, once per oscillator period
`timescale 1ns/1ps
`include "efield_defines.vh"

module osc_tick_gen (
   input wire i_clk,
   input wire i_rst,
   output reg o_osc_clk,
   output reg o_osc_tick
);

   reg [`OSC_DIV_W-1:0] div_q;

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         div_q <= {`OSC_DIV_W{1'b0}};
         o_osc_clk <= 1'b0;
         o_osc_tick <= 1'b0;
      end else begin
         o_osc_tick <= 1'b0;
         if (div_q == `OSC_HALF_CYC - 1) begin
            div_q <= {`OSC_DIV_W{1'b0}};
            o_osc_clk <= ~o_osc_clk;
            // one tick per full period, on the rising half
            o_osc_tick <= ~o_osc_clk;
         end else begin
            div_q <= div_q + 1'b1;
         end
      end
   end

endmodule

// *** efield_sva.sv ***
// Purpose: port checker for the select and supervisor block
// Assumes: one clock domain, async active-high reset
// Notes: supervisor release times are too long to watch here
`timescale 1ns/1ps
`include "efield_defines.vh"
module efield_sva (
   input wire i_clk,
   input wire i_rst,
   input wire i_sel_a,
   input wire i_sel_b,
   input wire i_sel_c,
   input wire i_sel_d,
   input wire i_vcc_low,
   input wire i_vcc_high,
   input wire i_lamp_on_req,
   input wire i_serial_bus_rx,
   input wire i_serial_tx_in,
   input wire [`PIN_W-1:0] o_tx_drive,
   input wire [`PIN_W-1:0] o_pin_ground,
   input wire [`RX_W-1:0] o_rx_connect,
   input wire o_clk_out,
   input wire o_rst_n,
   input wire o_lamp_switch,
   input wire o_serial_rx_out,
   input wire o_serial_bus_tx
);
   wire [3:0] code = {i_sel_d, i_sel_c, i_sel_b, i_sel_a};
   wire pin_sel = code >= 4'h1 && code <= 4'hb;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // ---------------------------------------------------------------
   // selectors, outputs and supervisor
   // ---------------------------------------------------------------
   sequence s_pin; pin_sel; endsequence
   sequence s_toggle; ##41 $changed(o_clk_out); endsequence
   property p_drive; s_pin |=> o_tx_drive == 11'h001 << ($past(code) - 4'h1); endproperty
   property p_nodrive; !pin_sel |=> o_tx_drive == 11'h000; endproperty
   property p_ground; 1'b1 |=> o_pin_ground ==
      ($past(pin_sel) ? ~(11'h001 << ($past(code) - 4'h1)) : 11'h7ff); endproperty
   property p_follow; o_tx_drive != 11'h000 |-> o_rx_connect == {3'h0, o_tx_drive}; endproperty
   property p_inner; code == 4'h0 || code == 4'hc || code == 4'hd |=> o_rx_connect ==
      ($past(code) == 4'h0 ? 14'h0800 : $past(code) == 4'hc ? 14'h1000 : 14'h2000); endproperty
   property p_none; code >= 4'he |=> o_rx_connect == 14'h0000; endproperty
   property p_lamp; 1'b1 |=> o_lamp_switch == $past(i_lamp_on_req); endproperty
   property p_serial; 1'b1 |=> o_serial_rx_out == $past(i_serial_bus_rx)
      && o_serial_bus_tx == $past(i_serial_tx_in); endproperty
   property p_clk; $changed(o_clk_out) |-> s_toggle; endproperty
   property p_supply; i_vcc_low || i_vcc_high |=> !o_rst_n; endproperty
   a_drive: assert property (p_drive) else $error("drive not on coded pin");
   a_nodrive: assert property (p_nodrive) else $error("pin driven for code");
   a_ground: assert property (p_ground) else $error("ground not inverse");
   a_follow: assert property (p_follow) else $error("detector off pin");
   a_inner: assert property (p_inner) else $error("internal node wrong");
   a_none: assert property (p_none) else $error("detector not open");
   a_lamp: assert property (p_lamp) else $error("lamp switch wrong");
   a_serial: assert property (p_serial) else $error("serial copy wrong");
   a_clk: assert property (p_clk) else $error("clock half period");
   a_supply: assert property (p_supply) else $error("reset not forced");
endmodule
bind efield_select_and_supervisor efield_sva i_sva (.*);

// *** host_model.sv ***
// Purpose: host controller model driving select lines and kicks
// Assumes: bench chooses the code; lamp and serial levels set by bench
// Notes: kick interval is far below the watchdog minimum
`timescale 1ns/1ps
module host_model #(parameter KICK_CYC = 500) (
   input wire i_clk,
   input wire [3:0] i_code,
   output wire o_sel_a,
   output wire o_sel_b,
   output wire o_sel_c,
   output wire o_sel_d,
   output reg o_wd_kick
);
   integer cnt_q = 0;
   assign {o_sel_d, o_sel_c, o_sel_b, o_sel_a} = i_code;
   initial o_wd_kick = 1'b0;
   // toggled off the sampling edge so the block never sees a race
   always @(negedge i_clk) begin
      cnt_q <= (cnt_q + 1) % KICK_CYC;
      if (cnt_q == 0) o_wd_kick <= ~o_wd_kick;
   end
endmodule

// *** tb.sv ***
// Purpose: self-checking bench for the select and supervisor block
// Assumes: 10 MHz clock, inputs changed at the falling edge
// Notes: power-on release lies beyond the run, only its hold is seen
`timescale 1ns/1ps
`include "efield_defines.vh"
module tb;
   logic i_clk, i_rst, vcc_low, vcc_high, lamp, bus_rx, tx_in;
   logic [3:0] code;
   wire sel_a, sel_b, sel_c, sel_d, kick, clk_out, rst_n, lamp_sw, rx_out, bus_tx;
   wire [`PIN_W-1:0] tx_drive, pin_ground;
   wire [`RX_W-1:0] rx_connect;
   integer errors = 0;
   integer checked = 0;
   host_model i_host (.i_clk(i_clk), .i_code(code), .o_sel_a(sel_a), .o_sel_b(sel_b),
      .o_sel_c(sel_c), .o_sel_d(sel_d), .o_wd_kick(kick));
   efield_select_and_supervisor i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_sel_a(sel_a),
      .i_sel_b(sel_b), .i_sel_c(sel_c), .i_sel_d(sel_d), .i_vcc_low(vcc_low),
      .i_vcc_high(vcc_high), .i_wd_kick(kick), .i_lamp_on_req(lamp),
      .i_serial_bus_rx(bus_rx), .i_serial_tx_in(tx_in), .o_tx_drive(tx_drive),
      .o_pin_ground(pin_ground), .o_rx_connect(rx_connect), .o_clk_out(clk_out),
      .o_rst_n(rst_n), .o_lamp_switch(lamp_sw), .o_serial_rx_out(rx_out),
      .o_serial_bus_tx(bus_tx));
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task summarize;
      if (errors == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task t_codes;
      logic [10:0] tx;
      logic [13:0] rx;
      for (int c = 0; c < 16; c++) begin
         @(negedge i_clk);
         code = c[3:0];
         @(negedge i_clk);
         tx = (c >= 1 && c <= 11) ? 11'h001 << (c - 1) : 11'h000;
         rx = c == 0 ? 14'h0800 : c == 12 ? 14'h1000 : c == 13 ? 14'h2000 : {3'h0, tx};
         chk(tx_drive, tx);
         chk(pin_ground, {5'h00, ~tx});
         chk(rx_connect, rx);
      end
   endtask
   task t_lamp_serial;
      for (int v = 0; v < 2; v++) begin
         @(negedge i_clk);
         lamp = v[0];
         bus_rx = ~v[0];
         tx_in = v[0];
         @(negedge i_clk);
         chk(lamp_sw, v[0]);
         chk({rx_out, bus_tx}, {~v[0], v[0]});
      end
   endtask
   task t_clk;
      logic last;
      int n;
      n = 0;
      last = clk_out;
      while (clk_out === last && n < 200) begin
         @(negedge i_clk);
         n++;
      end
      last = clk_out;
      n = 0;
      while (clk_out === last && n < 200) begin
         @(negedge i_clk);
         n++;
      end
      if (n >= 200) begin
         errors++;
         summarize;
      end
      else chk(n[15:0], 16'h0029);
   endtask
   task t_reset;
      @(negedge i_clk);
      code = 4'h3;
      i_rst = 1'b1;
      @(negedge i_clk);
      chk(tx_drive, 16'h0000);
      chk(pin_ground, 16'h07ff);
      chk(rx_connect, 16'h0000);
      chk({lamp_sw, rx_out, bus_tx, rst_n}, 16'h0006);
      i_rst = 1'b0;
      @(negedge i_clk);
      chk(tx_drive, 16'h0004);
      chk(pin_ground, 16'h07fb);
      chk(rx_connect, 16'h0004);
      chk({lamp_sw, rx_out, bus_tx}, 16'h0005);
   endtask
   task t_supply;
      int n;
      n = 0;
      @(negedge i_clk);
      vcc_low = 1'b1;
      // hold the fault across an oscillator rise to line up with its tick
      while (clk_out !== 1'b0 && n < 200) begin
         @(negedge i_clk);
         n++;
      end
      while (clk_out !== 1'b1 && n < 200) begin
         @(negedge i_clk);
         n++;
      end
      if (n >= 200) begin
         errors++;
         summarize;
      end else begin
         chk(i_dut.cnt_q, 16'h0000);
         chk(rst_n, 1'b0);
         vcc_low = 1'b0;
         repeat (`OSC_HALF_CYC * 6) @(negedge i_clk);
         chk(i_dut.cnt_q, 16'h0003);
         chk(rst_n, 1'b0);
         vcc_high = 1'b1;
         @(negedge i_clk);
         chk(i_dut.cnt_q, 16'h0000);
         chk(rst_n, 1'b0);
         vcc_high = 1'b0;
      end
   endtask
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   initial begin
      i_rst = 1'b1;
      code = 4'h0;
      {vcc_low, vcc_high, lamp} = 3'h0;
      {bus_rx, tx_in} = 2'h3;
      repeat (12) @(negedge i_clk);
      i_rst = 1'b0;
      t_codes;
      t_lamp_serial;
      t_reset;
      t_clk;
      t_supply;
      summarize;
   end
endmodule
